// ===== rtl/sgi_init_seq.sv
// device-side bring-up sequencer: reset, strap capture, calibration, clock start and init tracking
//
// Local design decisions: the placing of the registers and strobed register access.
`include "sgi_map.svh"
module sgi_init_seq #(
	parameter int INIT_DELAY_CYC = `SGI_CYC_DN(`SGI_INIT_DELAY_NS),
	parameter int TEMP_VALID_CYC = `SGI_CYC_UP(`SGI_TEMP_VALID_NS),
	parameter int CAL_CYC = `SGI_CAL_CYC,
	parameter int REFRESH_CYC = `SGI_REFRESH_CYC,
	parameter int STABLE_CLKS = `SGI_STABLE_CLKS
) (
	input wire logic CLOCK_IN,
	input wire logic SYS_RST_IN,
	input wire logic CHIP_RESET_N_IN,
	input wire logic SCAN_ISOLATE_IN,
	input wire logic CLK_ENABLE_N_IN,
	input wire logic MAIN_CLK_TICK_IN,
	input wire logic [6:0] CA_A_IN,
	input wire logic [6:0] CA_B_IN,
	input wire logic ERR_DETECT_A_IN,
	input wire logic ERR_DETECT_B_IN,
	input wire logic CMD_STB_IN,
	input wire sgi_pkg::sgi_cmd_t CMD_IN,
	input wire logic [3:0] MR_SEL_IN,
	input wire logic [3:0] REG_ADDR_IN,
	input wire logic [31:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [31:0] REG_RDATA_OUT,
	output logic DRV_HIZ_OUT,
	output logic DIE_TERM_EN_OUT,
	output logic CALIB_BUSY_OUT,
	output logic TEMP_VALID_OUT,
	output logic READY_OUT,
	output logic SEQ_ERR_OUT,
	output logic CA_TRAIN_OUT,
	output logic CMD_INV_EN_OUT,
	output logic [3:0] ERR_HOLD_OUT,
	output logic WIDTH_X16_OUT,
	output logic TWO_CH_OUT,
	output sgi_pkg::sgi_term_t CK_TERM_OUT,
	output logic [2:0] CA_LO_TERM_A_OUT,
	output logic [2:0] CA_HI_TERM_A_OUT,
	output logic [2:0] CA_LO_TERM_B_OUT,
	output logic [2:0] CA_HI_TERM_B_OUT,
	output sgi_pkg::sgi_state_t STATE_OUT
);
	import sgi_pkg::*;

	localparam int TW = `SGI_TIMER_W;
	localparam int CW = $clog2(STABLE_CLKS + 1);
	localparam int STRAP_HOLD_CYC = `SGI_CYC_UP(`SGI_STRAP_HOLD_NS);

	logic up;
	logic held;
	logic rise;
	logic iso;
	logic act;
	logic init_done;
	sgi_state_t state;
	sgi_state_t next_state;
	logic tmr_load;
	logic [TW-1:0] tmr_val;
	logic tmr_done;
	logic [CW-1:0] clk_cnt;
	logic [CW-1:0] next_clk_cnt;
	logic [1:0] ref_cnt;
	logic [1:0] next_ref_cnt;
	logic mode_set_seen;
	logic next_mode_set_seen;
	logic next_ca_train;
	logic rd_trained;
	logic next_rd_trained;
	logic wr_trained;
	logic next_wr_trained;
	logic err_evt;
	logic [TW-1:0] since_rel;
	logic [TW-1:0] next_since_rel;
	logic ca_term_en;
	logic next_ca_term_en;
	logic next_cmd_inv_en;
	logic [3:0] next_err_hold;
	logic next_seq_err;
	logic next_temp_valid;
	logic next_drv_hiz;
	logic next_die_term;
	sgi_term_t next_ck_term;
	logic [11:0] next_ca_term;
	logic [31:0] next_rdata;
	sgi_term_t ck_lat;
	logic [5:0] lo_lat;
	logic [5:0] hi_lat;
	logic wr_status;
	logic wr_mode;

	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (SYS_RST_IN);

	// pin level and scan isolation combine into one release condition
	assign up = CHIP_RESET_N_IN && !SCAN_ISOLATE_IN;
	assign iso = !up;
	assign rise = up && !held;
	assign act = CMD_STB_IN && (CMD_IN != SGI_CMD_NOP);
	assign init_done = (since_rel >= TW'(INIT_DELAY_CYC));
	assign wr_status = REG_WR_IN && (REG_ADDR_IN == `SGI_A_STATUS);
	assign wr_mode = REG_WR_IN && (REG_ADDR_IN == `SGI_A_MODE);

	// release edge detect and time since release
	always_comb begin
		next_since_rel = since_rel;
		if (iso) begin
			next_since_rel = '0;
		end else if (since_rel != '1) begin
			next_since_rel = since_rel + 1'b1;
		end
		next_temp_valid = up && (since_rel >= TW'(TEMP_VALID_CYC));
	end

	always_ff @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			held <= 1'b0;
			since_rel <= '0;
			TEMP_VALID_OUT <= 1'b0;
		end else begin
			held <= up;
			since_rel <= next_since_rel;
			TEMP_VALID_OUT <= next_temp_valid;
		end
	end

	// straps sampled at the release edge
	sgi_strap u_strap (
		.clk_in(CLOCK_IN),
		.rst_in(SYS_RST_IN),
		.latch_in(rise),
		.ca_a_in(CA_A_IN),
		.ca_b_in(CA_B_IN),
		.err_a_in(ERR_DETECT_A_IN),
		.err_b_in(ERR_DETECT_B_IN),
		.x16_out(WIDTH_X16_OUT),
		.two_ch_out(TWO_CH_OUT),
		.ck_term_out(ck_lat),
		.lo_term_out(lo_lat),
		.hi_term_out(hi_lat)
	);

	// phase timer for strap hold, calibration and refresh wait
	sgi_timer #(
		.W(TW)
	) u_timer (
		.clk_in(CLOCK_IN),
		.rst_in(SYS_RST_IN),
		.load_in(tmr_load),
		.val_in(tmr_val),
		.done_out(tmr_done)
	);

	// bring-up sequence tracking and order checks
	always_comb begin
		next_state = state;
		next_clk_cnt = clk_cnt;
		next_ref_cnt = ref_cnt;
		next_mode_set_seen = mode_set_seen;
		next_ca_train = CA_TRAIN_OUT;
		next_rd_trained = rd_trained;
		next_wr_trained = wr_trained;
		tmr_load = 1'b0;
		tmr_val = '0;
		err_evt = 1'b0;
		case (state)
			SGI_ST_RESET: begin
				// every reset resumes at strap capture
				if (rise) begin
					next_state = SGI_ST_HOLD;
					tmr_load = 1'b1;
					tmr_val = TW'(STRAP_HOLD_CYC);
					next_clk_cnt = '0;
					next_ref_cnt = 2'h0;
					next_mode_set_seen = 1'b0;
					next_ca_train = 1'b0;
					next_rd_trained = 1'b0;
					next_wr_trained = 1'b0;
				end
			end
			SGI_ST_HOLD: begin
				err_evt = act;
				if (tmr_done) begin
					next_state = SGI_ST_CALIB;
					tmr_load = 1'b1;
					tmr_val = TW'(CAL_CYC);
					err_evt = act || CLK_ENABLE_N_IN;
				end
			end
			SGI_ST_CALIB: begin
				// clock must stay idle until the delay
				err_evt = act || (MAIN_CLK_TICK_IN && !init_done);
				if (tmr_done) begin
					next_state = SGI_ST_CLKUP;
				end
			end
			SGI_ST_CLKUP: begin
				err_evt = act || (MAIN_CLK_TICK_IN && !init_done);
				if (MAIN_CLK_TICK_IN && init_done) begin
					next_clk_cnt = clk_cnt + 1'b1;
				end
				if (clk_cnt == CW'(STABLE_CLKS)) begin
					next_state = SGI_ST_MODE;
				end
			end
			SGI_ST_MODE: begin
				if (act) begin
					case (CMD_IN)
						SGI_CMD_MODE_SET: begin
							next_mode_set_seen = 1'b1;
							next_ca_train = (MR_SEL_IN == `SGI_MR_TRAIN);
						end
						SGI_CMD_REFRESH_ALL: begin
							err_evt = !mode_set_seen || CA_TRAIN_OUT;
							next_ca_train = 1'b0;
							next_ref_cnt = 2'h1;
							next_state = SGI_ST_REFR;
						end
						default: begin
							err_evt = !CA_TRAIN_OUT;
						end
					endcase
				end
			end
			SGI_ST_REFR: begin
				// two refreshes then the refresh cycle time
				if (act) begin
					if ((CMD_IN == SGI_CMD_REFRESH_ALL) && (ref_cnt == 2'h1)) begin
						next_ref_cnt = 2'h2;
						tmr_load = 1'b1;
						tmr_val = TW'(REFRESH_CYC);
					end else begin
						err_evt = 1'b1;
					end
				end else if ((ref_cnt == 2'h2) && tmr_done) begin
					next_state = SGI_ST_TRAIN;
				end
			end
			SGI_ST_TRAIN: begin
				if (act) begin
					case (CMD_IN)
						SGI_CMD_FIFO_LOAD,
						SGI_CMD_READ_TRAIN: begin
							next_rd_trained = 1'b1;
						end
						SGI_CMD_WRITE_TRAIN: begin
							next_wr_trained = 1'b1;
						end
						SGI_CMD_OTHER: begin
							err_evt = !(rd_trained && wr_trained);
							next_state = SGI_ST_READY;
						end
						default: begin
							next_state = SGI_ST_TRAIN;
						end
					endcase
				end
			end
			SGI_ST_READY: begin
				next_state = SGI_ST_READY;
			end
			default: begin
				next_state = SGI_ST_RESET;
			end
		endcase
		if (iso) begin
			next_state = SGI_ST_RESET;
			next_ca_train = 1'b0;
			err_evt = 1'b0;
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			state <= SGI_ST_RESET;
			clk_cnt <= '0;
			ref_cnt <= 2'h0;
			mode_set_seen <= 1'b0;
			CA_TRAIN_OUT <= 1'b0;
			rd_trained <= 1'b0;
			wr_trained <= 1'b0;
		end else begin
			state <= next_state;
			clk_cnt <= next_clk_cnt;
			ref_cnt <= next_ref_cnt;
			mode_set_seen <= next_mode_set_seen;
			CA_TRAIN_OUT <= next_ca_train;
			rd_trained <= next_rd_trained;
			wr_trained <= next_wr_trained;
		end
	end

	// mode defaults, software writes and the sticky order flag
	always_comb begin
		next_cmd_inv_en = CMD_INV_EN_OUT;
		next_ca_term_en = ca_term_en;
		next_err_hold = ERR_HOLD_OUT;
		next_seq_err = SEQ_ERR_OUT;
		if (wr_mode) begin
			next_cmd_inv_en = REG_WDATA_IN[`SGI_M_CMD_INV];
			next_ca_term_en = REG_WDATA_IN[`SGI_M_CATERM];
			next_err_hold = REG_WDATA_IN[`SGI_M_ERR_HOLD +: 4];
		end
		if (iso) begin
			next_cmd_inv_en = 1'b1;
			next_ca_term_en = 1'b1;
			next_err_hold = `SGI_ERR_HOLD_RST;
		end
		if (wr_status && REG_WDATA_IN[`SGI_S_ERR]) begin
			next_seq_err = 1'b0;
		end
		if (err_evt) begin
			next_seq_err = 1'b1; // set beats clear
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			CMD_INV_EN_OUT <= 1'b1;
			ca_term_en <= 1'b1;
			ERR_HOLD_OUT <= `SGI_ERR_HOLD_RST;
			SEQ_ERR_OUT <= 1'b0;
		end else begin
			CMD_INV_EN_OUT <= next_cmd_inv_en;
			ca_term_en <= next_ca_term_en;
			ERR_HOLD_OUT <= next_err_hold;
			SEQ_ERR_OUT <= next_seq_err;
		end
	end

	// pin-facing state outputs follow the next state
	always_comb begin
		next_drv_hiz = (next_state == SGI_ST_RESET);
		// termination off in reset, strap hold and calibration
		next_die_term = !(next_state inside {SGI_ST_RESET, SGI_ST_HOLD, SGI_ST_CALIB});
		next_ck_term = next_die_term ? ck_lat : SGI_TERM_OFF;
		next_ca_term = (next_die_term && next_ca_term_en) ? {hi_lat[5:3], lo_lat[5:3], hi_lat[2:0], lo_lat[2:0]} : '0;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			STATE_OUT <= SGI_ST_RESET;
			DRV_HIZ_OUT <= 1'b1;
			DIE_TERM_EN_OUT <= 1'b0;
			CALIB_BUSY_OUT <= 1'b0;
			READY_OUT <= 1'b0;
			CK_TERM_OUT <= SGI_TERM_OFF;
			{CA_HI_TERM_B_OUT, CA_LO_TERM_B_OUT, CA_HI_TERM_A_OUT, CA_LO_TERM_A_OUT} <= '0;
		end else begin
			STATE_OUT <= next_state;
			DRV_HIZ_OUT <= next_drv_hiz;
			DIE_TERM_EN_OUT <= next_die_term;
			CALIB_BUSY_OUT <= (next_state == SGI_ST_CALIB);
			READY_OUT <= (next_state == SGI_ST_READY);
			CK_TERM_OUT <= next_ck_term;
			{CA_HI_TERM_B_OUT, CA_LO_TERM_B_OUT, CA_HI_TERM_A_OUT, CA_LO_TERM_A_OUT} <= next_ca_term;
		end
	end

	// register read mux, data valid only in the cycle after the strobe
	always_comb begin
		next_rdata = '0;
		if (REG_RD_IN) begin
			case (REG_ADDR_IN)
				`SGI_A_STATUS: begin
					next_rdata = {18'h0, CA_TRAIN_OUT, DIE_TERM_EN_OUT, SEQ_ERR_OUT, TEMP_VALID_OUT,
						TWO_CH_OUT, WIDTH_X16_OUT, state};
				end
				`SGI_A_TERM: begin
					next_rdata = {17'h0, CA_HI_TERM_B_OUT, CA_LO_TERM_B_OUT, CA_HI_TERM_A_OUT,
						CA_LO_TERM_A_OUT, CK_TERM_OUT};
				end
				`SGI_A_MODE: begin
					next_rdata = {24'h0, ERR_HOLD_OUT, 2'h0, ca_term_en, CMD_INV_EN_OUT};
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (SYS_RST_IN) begin
			REG_RDATA_OUT <= '0;
		end else begin
			REG_RDATA_OUT <= next_rdata;
		end
	end

	sequence s_isolated;
		STATE_OUT == SGI_ST_RESET && DRV_HIZ_OUT && !DIE_TERM_EN_OUT;
	endsequence
	sequence s_hold_then_calib;
		(state == SGI_ST_HOLD) [*4] ##1 (state == SGI_ST_CALIB);
	endsequence

	mode_defaults_a: assert property (iso |=> CMD_INV_EN_OUT && ca_term_en && ERR_HOLD_OUT == 4'hf)
		else $error("mode defaults not restored by reset");
	hold_calib_a: assert property (disable iff (SYS_RST_IN || iso)
		rise |=> s_hold_then_calib)
		else $error("strap hold or calibration entry mistimed");
	odt_deadline_a: assert property (init_done && !iso && since_rel > TW'(CAL_CYC + 8)
		|-> DIE_TERM_EN_OUT && CK_TERM_OUT == $past(ck_lat))
		else $error("termination not enabled within init delay");
	temp_valid_a: assert property (TEMP_VALID_OUT |-> since_rel > TW'(TEMP_VALID_CYC))
		else $error("temperature valid too early");
	reset_entry_a: assert property (iso |=> s_isolated)
		else $error("reset state not entered at once");
	odt_off_a: assert property ($fell(CHIP_RESET_N_IN) |=> CK_TERM_OUT == SGI_TERM_OFF
		&& CA_LO_TERM_A_OUT == 3'h0 && CA_HI_TERM_B_OUT == 3'h0)
		else $error("termination not disabled in reset");
endmodule // sgi_init_seq

// ===== rtl/sgi_map.svh
// offsets, field positions, reset values and timing counts of the bring-up sequencer
`ifndef SGI_MAP_SVH
`define SGI_MAP_SVH
`define SGI_CLK_PS 4000
`define SGI_CYC_UP(ns) ((((ns) * 1000) + `SGI_CLK_PS - 1) / `SGI_CLK_PS)
`define SGI_CYC_DN(ns) (((ns) * 1000) / `SGI_CLK_PS)
`define SGI_STRAP_HOLD_NS 10
`define SGI_INIT_DELAY_NS 1000000
`define SGI_TEMP_VALID_NS 1500000
`define SGI_STABLE_CLKS 100
`define SGI_CAL_CYC 1024
`define SGI_REFRESH_CYC 128
`define SGI_TIMER_W 20
`define SGI_MR_TRAIN 4'hf
`define SGI_A_STATUS 4'h0
`define SGI_A_TERM 4'h4
`define SGI_A_MODE 4'h8
`define SGI_S_ERR 11
`define SGI_M_CMD_INV 0
`define SGI_M_CATERM 1
`define SGI_M_ERR_HOLD 4
`define SGI_ERR_HOLD_RST 4'hf
`endif

// ===== rtl/sgi_pkg.sv
// types shared by the bring-up sequencer modules
package sgi_pkg;
	typedef enum logic [7:0] {
		SGI_ST_RESET = 8'h01,
		SGI_ST_HOLD = 8'h02,
		SGI_ST_CALIB = 8'h04,
		SGI_ST_CLKUP = 8'h08,
		SGI_ST_MODE = 8'h10,
		SGI_ST_REFR = 8'h20,
		SGI_ST_TRAIN = 8'h40,
		SGI_ST_READY = 8'h80
	} sgi_state_t;
	typedef enum logic [2:0] {
		SGI_CMD_NOP = 3'h0,
		SGI_CMD_MODE_SET = 3'h1,
		SGI_CMD_REFRESH_ALL = 3'h2,
		SGI_CMD_FIFO_LOAD = 3'h3,
		SGI_CMD_READ_TRAIN = 3'h4,
		SGI_CMD_WRITE_TRAIN = 3'h5,
		SGI_CMD_OTHER = 3'h6
	} sgi_cmd_t;
	typedef enum logic [2:0] {
		SGI_TERM_OFF = 3'h0,
		SGI_TERM_60 = 3'h1,
		SGI_TERM_120 = 3'h2,
		SGI_TERM_240 = 3'h3,
		SGI_TERM_RSVD = 3'h4
	} sgi_term_t;
endpackage

// ===== rtl/sgi_strap.sv
// strap capture and termination decode, held until the next release
module sgi_strap (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic latch_in,
	input wire logic [6:0] ca_a_in,
	input wire logic [6:0] ca_b_in,
	input wire logic err_a_in,
	input wire logic err_b_in,
	output logic x16_out,
	output logic two_ch_out,
	output sgi_pkg::sgi_term_t ck_term_out,
	output wire logic [5:0] lo_term_out,
	output wire logic [5:0] hi_term_out
);
	import sgi_pkg::*;
	logic next_x16;
	logic next_two_ch;
	sgi_term_t next_ck_term;

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// width, channel mode and clock termination sampled only at release
	always_comb begin
		next_x16 = x16_out;
		next_two_ch = two_ch_out;
		next_ck_term = ck_term_out;
		if (latch_in) begin
			next_x16 = err_a_in & err_b_in;
			next_two_ch = ca_a_in[6] & ca_b_in[6];
			next_ck_term = !ca_a_in[5] ? SGI_TERM_OFF : (ca_a_in[4] ? SGI_TERM_120 : SGI_TERM_60);
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			x16_out <= 1'b0;
			two_ch_out <= 1'b0;
			ck_term_out <= SGI_TERM_OFF;
		end else begin
			x16_out <= next_x16;
			two_ch_out <= next_two_ch;
			ck_term_out <= next_ck_term;
		end
	end

	// per-channel command termination: channel A on bits 1:0, channel B on bits 3:2
	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic [1:0] code;
		logic ch_two;
		sgi_term_t lo;
		sgi_term_t hi;
		sgi_term_t next_lo;
		sgi_term_t next_hi;
		assign code = (c == 0) ? ca_a_in[1:0] : ca_b_in[3:2];
		assign ch_two = (c == 0) ? ca_a_in[6] : ca_b_in[6];
		always_comb begin
			next_lo = lo;
			next_hi = hi;
			if (latch_in) begin
				case (code)
					2'b00: begin
						next_lo = SGI_TERM_OFF;
						next_hi = SGI_TERM_OFF;
					end
					2'b01: begin
						next_lo = SGI_TERM_60;
						next_hi = ch_two ? SGI_TERM_60 : SGI_TERM_120;
					end
					2'b10: begin
						next_lo = SGI_TERM_120;
						next_hi = ch_two ? SGI_TERM_120 : SGI_TERM_240;
					end
					default: begin
						next_lo = SGI_TERM_RSVD;
						next_hi = SGI_TERM_RSVD;
					end
				endcase
			end
		end
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				lo <= SGI_TERM_OFF;
				hi <= SGI_TERM_OFF;
			end else begin
				lo <= next_lo;
				hi <= next_hi;
			end
		end
		assign lo_term_out[3*c +: 3] = lo;
		assign hi_term_out[3*c +: 3] = hi;
	end

	x16_latch_a: assert property (latch_in |=> x16_out == $past(err_a_in & err_b_in))
		else $error("width strap not latched");
	chmode_latch_a: assert property (latch_in |=> two_ch_out == $past(ca_a_in[6] & ca_b_in[6]))
		else $error("channel mode strap not latched");
	ck_term_a: assert property (latch_in && ca_a_in[5] && !ca_a_in[4] |=> ck_term_out == SGI_TERM_60)
		else $error("clock termination decode wrong");
	ca_term_a: assert property (latch_in && ca_b_in[3:2] == 2'b10 |=> lo_term_out[5:3] == 3'h2)
		else $error("command termination decode wrong");
	upper_term_a: assert property (latch_in && ^ca_a_in[1:0] && !ca_a_in[6]
		|=> hi_term_out[2:0] == $past(ca_a_in[1] ? 3'h3 : 3'h2))
		else $error("upper termination not doubled");
	strap_hold_a: assert property (!latch_in |=> $stable(lo_term_out) && $stable(hi_term_out)
		&& $stable(x16_out) && $stable(two_ch_out))
		else $error("strap configuration changed without release");
endmodule // sgi_strap

// ===== rtl/sgi_timer.sv
// down-counter that reports zero, reloaded on demand
module sgi_timer #(
	parameter int W = 20
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic load_in,
	input wire logic [W-1:0] val_in,
	output logic done_out
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;

	// reload wins, otherwise count down to zero and stay
	always_comb begin
		next_cnt = cnt;
		if (load_in) begin
			next_cnt = val_in;
		end else if (cnt != '0) begin
			next_cnt = cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign done_out = (cnt == '0);
endmodule // sgi_timer

// ===== verification/sgi_ctrl_model.sv
// controller model: reset pin, straps, clock ticks and bring-up commands
module sgi_ctrl_model #(
	parameter int INIT_CYC = 200,
	parameter int STABLE = 10,
	parameter int REF_CYC = 16
) (
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic skip_in,
	input wire logic [15:0] cfg_in,
	output logic rst_n_out,
	output logic cke_n_out,
	output logic tick_out,
	output logic [15:0] strap_out,
	output logic stb_out,
	output sgi_pkg::sgi_cmd_t cmd_out,
	output logic [3:0] mr_out,
	output logic done_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import sgi_pkg::*;
	logic cold;
	task automatic issue(input sgi_cmd_t c, input logic [3:0] mr);
		stb_out <= 1'b1;
		cmd_out <= c;
		mr_out <= mr;
		@(posedge clk_in);
		stb_out <= 1'b0;
		cmd_out <= SGI_CMD_NOP;
		mr_out <= ~mr;
		repeat (2) @(posedge clk_in);
	endtask
	// idle pins at time zero
	initial begin
		cold = 1'b1;
		rst_n_out = 1'b0;
		cke_n_out = 1'b1;
		tick_out = 1'b0;
		strap_out = '0;
		stb_out = 1'b0;
		cmd_out = SGI_CMD_NOP;
		mr_out = '0;
		done_out = 1'b0;
		// bring-up sequence started by go_in, one process drives every pin
		forever begin
			@(posedge clk_in);
			if (go_in) begin
			done_out <= 1'b0;
			rst_n_out <= 1'b0;
			cke_n_out <= 1'b1;
			repeat (cold ? 50000 : 25) @(posedge clk_in);
			cold = 1'b0;
			// straps set, clock parked, then release
			strap_out <= cfg_in;
			repeat (3) @(posedge clk_in);
			rst_n_out <= 1'b1;
			repeat (3) @(posedge clk_in);
			// clock enable low, strap lines let go
			cke_n_out <= 1'b0;
			strap_out <= ~cfg_in;
			// clock only after the start delay
			repeat (INIT_CYC) @(posedge clk_in);
			repeat (STABLE) begin
				tick_out <= 1'b1;
				@(posedge clk_in);
				tick_out <= 1'b0;
				@(posedge clk_in);
			end
			repeat (2) @(posedge clk_in);
			issue(SGI_CMD_MODE_SET, 4'hf);
			issue(SGI_CMD_MODE_SET, 4'h3);
			issue(SGI_CMD_MODE_SET, 4'ha);
			// two refreshes then the refresh wait
			issue(SGI_CMD_REFRESH_ALL, 4'h0);
			issue(SGI_CMD_REFRESH_ALL, 4'h0);
			repeat (REF_CYC + 4) @(posedge clk_in);
			// read and write training before normal traffic
			issue(SGI_CMD_FIFO_LOAD, 4'h0);
			issue(SGI_CMD_READ_TRAIN, 4'h0);
			if (!skip_in)
				issue(SGI_CMD_WRITE_TRAIN, 4'h0);
			issue(SGI_CMD_OTHER, 4'h0);
			done_out <= 1'b1;
			end
		end
	end
endmodule // sgi_ctrl_model

// ===== verification/tb_sgram_powerup_init_sequence.sv
// bench: controller model on the link, tasks on the register port
module tb_sgram_powerup_init_sequence;
	timeunit 1ns;
	timeprecision 1ps;
	import sgi_pkg::*;
	logic clk, sys_rst, scan_iso, reg_wr, reg_rd, go, skip, rst_n, cke_n, tick, stb, done, xw, tc;
	logic hiz, term_en, calib, temp_ok, ready, seq_err, ca_train, cmd_inv, x16, two_ch;
	logic [3:0] reg_addr, mr, err_hold;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] cfg, strap;
	logic [14:0] exp_t;
	logic [2:0] lo_a, hi_a, lo_b, hi_b;
	logic [15:0] cfgs [3] = '{16'he471, 16'h0222, 16'h6013};
	sgi_cmd_t cmd;
	sgi_term_t ck_term;
	sgi_state_t state;
	int fails, checks_done;
	sgi_ctrl_model ctrl (.clk_in(clk), .go_in(go), .skip_in(skip),
		.cfg_in(cfg), .rst_n_out(rst_n), .cke_n_out(cke_n), .tick_out(tick), .strap_out(strap), .stb_out(stb),
		.cmd_out(cmd), .mr_out(mr), .done_out(done));
	sgi_init_seq #(.INIT_DELAY_CYC(200), .TEMP_VALID_CYC(300), .CAL_CYC(16), .REFRESH_CYC(16),
		.STABLE_CLKS(10)) dut (.CLOCK_IN(clk), .SYS_RST_IN(sys_rst), .CHIP_RESET_N_IN(rst_n),
		.SCAN_ISOLATE_IN(scan_iso), .CLK_ENABLE_N_IN(cke_n), .MAIN_CLK_TICK_IN(tick), .CA_A_IN(strap[6:0]),
		.CA_B_IN(strap[13:7]), .ERR_DETECT_A_IN(strap[14]), .ERR_DETECT_B_IN(strap[15]), .CMD_STB_IN(stb),
		.CMD_IN(cmd), .MR_SEL_IN(mr), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr),
		.REG_RD_IN(reg_rd), .REG_RDATA_OUT(reg_rdata), .DRV_HIZ_OUT(hiz), .DIE_TERM_EN_OUT(term_en),
		.CALIB_BUSY_OUT(calib), .TEMP_VALID_OUT(temp_ok), .READY_OUT(ready), .SEQ_ERR_OUT(seq_err),
		.CA_TRAIN_OUT(ca_train), .CMD_INV_EN_OUT(cmd_inv), .ERR_HOLD_OUT(err_hold), .WIDTH_X16_OUT(x16),
		.TWO_CH_OUT(two_ch), .CK_TERM_OUT(ck_term), .CA_LO_TERM_A_OUT(lo_a), .CA_HI_TERM_A_OUT(hi_a),
		.CA_LO_TERM_B_OUT(lo_b), .CA_HI_TERM_B_OUT(hi_b), .STATE_OUT(state));
	// verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// compare, count and report
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// one-cycle read strobe, data taken in the following cycle
	task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		check(reg_rdata, exp);
	endtask
	// expected termination codes from a strap word
	function automatic logic [2:0] lo_code(input logic [1:0] s);
		return (s == 2'b11) ? 3'h4 : {1'b0, s};
	endfunction
	function automatic logic [2:0] hi_code(input logic [1:0] s, input logic wide);
		return (wide || s == 2'b00 || s == 2'b11) ? lo_code(s) : lo_code(s) + 3'h1;
	endfunction
	function automatic logic [14:0] term_exp(input logic [15:0] c);
		return {hi_code(c[10:9], c[13]), lo_code(c[10:9]), hi_code(c[1:0], c[6]), lo_code(c[1:0]),
			1'b0, c[5] & c[4], c[5] & ~c[4]};
	endfunction
	// start the model, check the reset phase, wait for the sequence end
	task automatic bring_up(input logic [15:0] c, input logic sk);
		int n;
		logic [1:0] seen;
		n = 0;
		seen = 2'b00;
		cfg <= c;
		skip <= sk;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (2) @(posedge clk);
		check({hiz, term_en, state}, {2'b10, SGI_ST_RESET}); // reset forced, termination off
		while (done !== 1'b1 && n < 60000) begin
			@(posedge clk);
			seen = seen | {calib, ca_train};
			n++;
		end
		if (n == 60000) begin
			fails++;
			stop_test();
		end
		check(seen, 2'b11); // calibration and training seen
	endtask
	// clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// main sequence
	initial begin
		sys_rst <= 1'b1;
		scan_iso <= 1'b0;
		reg_addr <= 4'h0;
		reg_wdata <= 32'h0;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		go <= 1'b0;
		skip <= 1'b0;
		cfg <= 16'h0;
		fails = 0;
		checks_done = 0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		reg_check(4'h8, 32'hf3); // mode defaults
		reg_check(4'hc, 32'h0); // unmapped word reads zero
		for (int i = 0; i < 3; i++) begin
			bring_up(cfgs[i], 1'b0); // cold then warm restarts
			exp_t = term_exp(cfgs[i]);
			xw = cfgs[i][15] & cfgs[i][14];
			tc = cfgs[i][13] & cfgs[i][6];
			check({ready, seq_err, temp_ok, term_en}, 4'b1001); // ready, temperature early
			check({x16, two_ch}, {xw, tc}); // latched straps
			check({hi_b, lo_b, hi_a, lo_a, ck_term}, exp_t); // termination
			reg_check(4'h0, {18'h0, 4'b0100, tc, xw, 8'h80}); // status word
			reg_check(4'h4, {17'h0, exp_t}); // termination word
			repeat (40) @(posedge clk);
			check(temp_ok, 1'b1); // temperature valid later
		end
		bring_up(cfgs[0], 1'b1); // write training skipped
		check(seq_err, 1'b1); // missing write training flagged
		reg_write(4'h0, 32'h800); // clear order flag
		repeat (2) @(posedge clk);
		check(seq_err, 1'b0); // order flag cleared
		reg_write(4'h8, 32'h51); // program mode fields
		reg_check(4'h8, 32'h51); // mode fields writable
		check({cmd_inv, err_hold, lo_a, hi_a, lo_b, hi_b, ck_term}, {1'b1, 4'h5, 12'h0, 3'h2}); // command term off
		scan_iso <= 1'b1;
		repeat (2) @(posedge clk);
		check({hiz, term_en, state}, {2'b10, SGI_ST_RESET}); // scan isolation forces reset
		reg_check(4'h8, 32'hf3); // defaults restored
		scan_iso <= 1'b0;
		stop_test();
	end
endmodule // tb_sgram_powerup_init_sequence
